// file: rtl/cdssc_pkg.sv
// Package with register map, field layout, strap tables and timing for the divider control block.
package cdssc_pkg;

  // ****************************************************************
  // Register map
  // ****************************************************************
  localparam int          CDSSC_NUM_OUT  = 4;
  localparam int          CDSSC_NUM_PIN  = 6;
  localparam int          CDSSC_ADDR_W   = 13;
  localparam int          CDSSC_RATIO_W  = 10;
  // Control register of each output, and the ratio low byte one address above it.
  localparam logic [12:0] CDSSC_CTRL_ADDR [CDSSC_NUM_OUT] = '{13'h0019, 13'h001F,
                                                             13'h0025, 13'h002B};
  localparam logic [12:0] CDSSC_RATIO_OFS = 13'h0001;

  // ****************************************************************
  // Control register fields
  // ****************************************************************
  localparam int          CDSSC_PD_BIT     = 7;
  localparam int          CDSSC_MASK_BIT   = 6;
  localparam int          CDSSC_LVL_HI     = 5;
  localparam int          CDSSC_LVL_LO     = 4;
  localparam int          CDSSC_ACTIVE_BIT = 2;
  localparam int          CDSSC_DIVHI_HI   = 1;

  // Logic level codes; the last one is the normal toggle mode.
  localparam logic [1:0]  CDSSC_LVL_LVDS   = 2'h0;
  localparam logic [1:0]  CDSSC_LVL_HSTL   = 2'h1;
  localparam logic [1:0]  CDSSC_LVL_CMOS   = 2'h2;
  localparam logic [1:0]  CDSSC_LVL_TOGGLE = 2'h3;

  // Reset values: divide by one, toggle mode, unmasked, running.
  localparam logic [9:0]  CDSSC_RATIO_RST  = 10'h000;
  localparam logic [1:0]  CDSSC_LVL_RST    = CDSSC_LVL_TOGGLE;

  // ****************************************************************
  // Strap tables, indexed by scanned level 0 to 7
  // ****************************************************************
  // Divide ratio minus one: 1, 2, 3, 4, 5, 6, 8, 16.
  localparam logic [9:0]  CDSSC_STRAP_RATIO_M1 [8] = '{10'h000, 10'h001, 10'h002, 10'h003,
                                                      10'h004, 10'h005, 10'h007, 10'h00F};
  // One bit per level: set where the even or odd output is high impedance or LVDS.
  localparam logic [7:0]  CDSSC_EVEN_HIZ  = 8'hA4;
  localparam logic [7:0]  CDSSC_EVEN_LVDS = 8'h12;
  localparam logic [7:0]  CDSSC_ODD_HIZ   = 8'hC0;
  localparam logic [7:0]  CDSSC_ODD_LVDS  = 8'h38;
  localparam int          CDSSC_TYPE_PIN0 = 4;

  // ****************************************************************
  // Timing
  // ****************************************************************
  localparam real         CDSSC_CLK_MHZ      = 200.0;
  localparam real         CDSSC_SCAN_SLOT_NS = 40.0;
  localparam int          CDSSC_SCAN_SLOT_CYC =
    (int'($ceil(CDSSC_SCAN_SLOT_NS * CDSSC_CLK_MHZ / 1000.0)) < 1) ? 1 :
    int'($ceil(CDSSC_SCAN_SLOT_NS * CDSSC_CLK_MHZ / 1000.0));
  localparam logic [3:0]  CDSSC_SLOT_LAST = 4'(CDSSC_SCAN_SLOT_CYC - 1);
  localparam logic [2:0]  CDSSC_PIN_LAST  = 3'(CDSSC_NUM_PIN - 1);

  // ****************************************************************
  // Carriers
  // ****************************************************************
  typedef struct packed {
    logic       enable;
    logic       power_down;
    logic       sync_mask;
    logic [1:0] level;
    logic [9:0] ratio_m1;
  } cdssc_out_cfg_t;

  typedef struct packed {
    logic       hit;
    logic       is_ratio;
    logic [1:0] idx;
  } cdssc_decode_t;

endpackage

// file: rtl/cdssc_divider.sv
// One output divider with hold, power-down and aligned restart.
`timescale 1ns/1ps
module cdssc_divider (
  input  wire logic       clk,
  input  wire logic       rst,
  input  wire logic       run,
  input  wire logic       hold,
  input  wire logic       hold_low,
  input  wire logic [9:0] ratio_m1,
  output logic            clk_out
);

  logic [9:0] cnt;
  logic [9:0] next_cnt;
  logic       next_out;

  // The counter parks at its top while held, so the first free cycle toggles
  // the output on every unmasked divider at once, whatever its ratio; toggle-mode outputs go high.
  always_comb begin
    next_cnt = cnt;
    next_out = clk_out;
    if (!run) begin
      next_cnt = '1;
      next_out = 1'b0;
    end else if (hold) begin
      next_cnt = '1; // [R05]
      if (hold_low) begin
        next_out = 1'b0; // [R07]
      end
    end else if (cnt >= ratio_m1) begin
      next_cnt = '0;
      next_out = ~clk_out;
    end else begin
      next_cnt = cnt + 10'h001;
    end
  end

  // State register; reset parks the counter so power-up outputs are aligned.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cnt     <= '1;
      clk_out <= 1'b0;
    end else begin
      cnt     <= next_cnt;
      clk_out <= next_out;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  held_low_a: assert property (run && hold && hold_low |=> !clk_out) // [R07]
    else $error("Held output in toggle mode is not low.");
  release_rise_a: assert property ($past(run) && $past(hold) && $past(hold_low) && run && !hold
                                   |=> clk_out) // [R05]
    else $error("Output did not rise on the first cycle after release.");
  stopped_low_a: assert property (!run [*2] |-> !clk_out) // [R01]
    else $error("Powered-down divider output is not low.");

endmodule

// file: rtl/cdssc_ctrl.sv
// Top of the four-output divider control with power-down, sync and strap scanning.
//
// Function
// R01 - Serial mode: control bit 7 of each output register powers that divider down.
// R02 - Device is powered down while the reset pin is held asserted.
// R03 - After reset every divider runs at ratio one, outputs aligned without sync.
// R04 - Controller pulses sync after ratio or phase changes when alignment is wanted.
// R05 - Sync low holds unmasked outputs static; release restarts them edge aligned.
// R06 - An output with its sync mask set keeps toggling through a sync.
// R07 - Unmasked outputs in toggle level mode are driven low while sync is low.
// R08 - Strap select high ignores registers; strap pins set ratio, type or high impedance.
// R09 - Strap mode: ratio at most sixteen, no phase offset, LVDS or HSTL only.
// R10 - Strap settings apply after a scan; scans start at reset and on sync toggle.
// R11 - Controller toggles sync before changed strap settings are accepted.
// R12 - Strap pins zero to three pick their output ratio from levels zero to seven.
// R13 - Strap pin four sets outputs zero and one, pin five outputs two and three.
// R14 - Synchronisation takes place on the rising edge of the sync pin.
// R15 - Each pin's scan gives a three-bit level; decoded settings latch at scan end.
`timescale 1ns/1ps
module cdssc_ctrl (
  input  wire logic                      clk,
  input  wire logic                      rst,
  input  wire logic                      sync_n,
  input  wire logic                      strap_mode_select,
  input  wire logic [2:0]                strap_level,
  input  wire logic                      reg_wr_en,
  input  wire logic                      reg_rd_en,
  input  wire logic [12:0]               reg_addr,
  input  wire logic [7:0]                reg_wdata,
  output logic      [7:0]                reg_rdata,
  output logic                           reg_rd_valid,
  output logic      [3:0]                clock_output,
  output logic      [3:0]                output_enable,
  output logic      [3:0][1:0]           output_type,
  output logic      [2:0]                strap_scan_pin,
  output logic                           strap_scan_busy,
  output logic                           device_power_down
);

  // ****************************************************************
  // Helper functions
  // ****************************************************************

  // Address decode shared by the write and read paths.
  function automatic cdssc_pkg::cdssc_decode_t decode(input logic [12:0] addr);
    cdssc_pkg::cdssc_decode_t d;
    d = '0;
    for (int i = 0; i < cdssc_pkg::CDSSC_NUM_OUT; i++) begin
      if (addr == cdssc_pkg::CDSSC_CTRL_ADDR[i]) begin
        d.hit = 1'b1;
        d.idx = 2'(i);
      end
      if (addr == cdssc_pkg::CDSSC_CTRL_ADDR[i] + cdssc_pkg::CDSSC_RATIO_OFS) begin
        d.hit      = 1'b1;
        d.is_ratio = 1'b1;
        d.idx      = 2'(i);
      end
    end
    return d;
  endfunction

  // Strap decode for one output: ratio from its own pin, type from the shared pin.
  function automatic cdssc_pkg::cdssc_out_cfg_t strap_cfg(input logic [2:0] ratio_lvl,
                                                          input logic [2:0] type_lvl,
                                                          input logic       odd);
    cdssc_pkg::cdssc_out_cfg_t c;
    logic hiz;
    logic lvds;
    c          = '0;
    hiz        = odd ? cdssc_pkg::CDSSC_ODD_HIZ[type_lvl] : cdssc_pkg::CDSSC_EVEN_HIZ[type_lvl];
    lvds       = odd ? cdssc_pkg::CDSSC_ODD_LVDS[type_lvl] : cdssc_pkg::CDSSC_EVEN_LVDS[type_lvl];
    c.ratio_m1 = cdssc_pkg::CDSSC_STRAP_RATIO_M1[ratio_lvl]; // [R12] [R09]
    c.enable   = ~hiz; // [R13]
    c.level    = lvds ? cdssc_pkg::CDSSC_LVL_LVDS : cdssc_pkg::CDSSC_LVL_HSTL; // [R09]
    return c;
  endfunction

  // ****************************************************************
  // Register file
  // ****************************************************************
  typedef enum {SCAN_IDLE, SCAN_RUN, SCAN_APPLY} cdssc_scan_t;

  cdssc_pkg::cdssc_out_cfg_t        reg_cfg        [cdssc_pkg::CDSSC_NUM_OUT];
  cdssc_pkg::cdssc_out_cfg_t        next_reg_cfg   [cdssc_pkg::CDSSC_NUM_OUT];
  cdssc_pkg::cdssc_out_cfg_t        strap_set      [cdssc_pkg::CDSSC_NUM_OUT];
  cdssc_pkg::cdssc_out_cfg_t        next_strap_set [cdssc_pkg::CDSSC_NUM_OUT];
  cdssc_pkg::cdssc_out_cfg_t        eff_cfg        [cdssc_pkg::CDSSC_NUM_OUT];
  cdssc_pkg::cdssc_decode_t         wr_dec;
  cdssc_pkg::cdssc_decode_t         rd_dec;
  logic [7:0]                       next_rdata;
  logic [3:0]                       active;
  logic [3:0]                       hold;
  logic [3:0]                       hold_low;
  logic [3:0]                       next_enable;
  logic [3:0][1:0]                  next_type;
  logic                             sync_q;
  logic                             sync_rise;
  cdssc_scan_t                      scan_state;
  cdssc_scan_t                      next_scan_state;
  logic [3:0]                       slot_cnt;
  logic [3:0]                       next_slot_cnt;
  logic [2:0]                       next_pin;
  logic [2:0]                       shadow      [cdssc_pkg::CDSSC_NUM_PIN];
  logic [2:0]                       next_shadow [cdssc_pkg::CDSSC_NUM_PIN];
  logic                             strap_valid;
  logic                             next_strap_valid;
  logic                             next_busy;

  assign wr_dec = decode(reg_addr);
  assign rd_dec = decode(reg_addr);

  // Register writes; in strap mode the serial configuration is ignored entirely.
  always_comb begin
    for (int i = 0; i < cdssc_pkg::CDSSC_NUM_OUT; i++) begin
      next_reg_cfg[i] = reg_cfg[i];
    end
    if (reg_wr_en && wr_dec.hit && !strap_mode_select) begin // [R08]
      if (wr_dec.is_ratio) begin
        next_reg_cfg[wr_dec.idx].ratio_m1[7:0] = reg_wdata;
      end else begin
        next_reg_cfg[wr_dec.idx].power_down = reg_wdata[cdssc_pkg::CDSSC_PD_BIT]; // [R01]
        next_reg_cfg[wr_dec.idx].sync_mask  = reg_wdata[cdssc_pkg::CDSSC_MASK_BIT]; // [R06]
        next_reg_cfg[wr_dec.idx].level      =
          reg_wdata[cdssc_pkg::CDSSC_LVL_HI:cdssc_pkg::CDSSC_LVL_LO];
        next_reg_cfg[wr_dec.idx].ratio_m1[9:8] = reg_wdata[cdssc_pkg::CDSSC_DIVHI_HI:0];
      end
    end
  end

  // Read data: control fields plus a live bit saying the divider is running free.
  always_comb begin
    next_rdata = '0;
    if (rd_dec.hit) begin
      if (rd_dec.is_ratio) begin
        next_rdata = reg_cfg[rd_dec.idx].ratio_m1[7:0];
      end else begin
        next_rdata[cdssc_pkg::CDSSC_PD_BIT]   = reg_cfg[rd_dec.idx].power_down;
        next_rdata[cdssc_pkg::CDSSC_MASK_BIT] = reg_cfg[rd_dec.idx].sync_mask;
        next_rdata[cdssc_pkg::CDSSC_LVL_HI:cdssc_pkg::CDSSC_LVL_LO] = reg_cfg[rd_dec.idx].level;
        next_rdata[cdssc_pkg::CDSSC_ACTIVE_BIT] = active[rd_dec.idx];
        next_rdata[cdssc_pkg::CDSSC_DIVHI_HI:0] = reg_cfg[rd_dec.idx].ratio_m1[9:8];
      end
    end
  end

  // Reset restores ratio one in toggle mode, which is why no sync is needed at power-up.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      for (int i = 0; i < cdssc_pkg::CDSSC_NUM_OUT; i++) begin
        reg_cfg[i] <= '{enable: 1'b1, power_down: 1'b0, sync_mask: 1'b0,
                        level: cdssc_pkg::CDSSC_LVL_RST,
                        ratio_m1: cdssc_pkg::CDSSC_RATIO_RST}; // [R03]
      end
      reg_rdata         <= '0;
      reg_rd_valid      <= 1'b0;
      device_power_down <= 1'b1; // [R02]
    end else begin
      for (int i = 0; i < cdssc_pkg::CDSSC_NUM_OUT; i++) begin
        reg_cfg[i] <= next_reg_cfg[i];
      end
      reg_rdata         <= reg_rd_en ? next_rdata : '0;
      reg_rd_valid      <= reg_rd_en;
      device_power_down <= 1'b0;
    end
  end

  // ****************************************************************
  // Strap scan
  // ****************************************************************

  // The release of sync is the toggle that triggers a rescan and the alignment point.
  assign sync_rise = sync_n && !sync_q; // [R14]

  // Each pin gets one slot; its level is sampled in the slot's last cycle, and the
  // decoded set only replaces the live one after all six pins, so a half scan never shows.
  always_comb begin
    next_scan_state  = scan_state;
    next_slot_cnt    = slot_cnt;
    next_pin         = strap_scan_pin;
    next_strap_valid = strap_valid;
    for (int p = 0; p < cdssc_pkg::CDSSC_NUM_PIN; p++) begin
      next_shadow[p] = shadow[p];
    end
    for (int i = 0; i < cdssc_pkg::CDSSC_NUM_OUT; i++) begin
      next_strap_set[i] = strap_set[i];
    end
    case (scan_state)
      SCAN_IDLE: begin
        if (sync_rise) begin // [R10]
          next_scan_state = SCAN_RUN;
          next_slot_cnt   = '0;
          next_pin        = '0;
        end
      end
      SCAN_RUN: begin
        if (slot_cnt == cdssc_pkg::CDSSC_SLOT_LAST) begin
          next_shadow[strap_scan_pin] = strap_level; // [R15]
          next_slot_cnt = '0;
          if (strap_scan_pin == cdssc_pkg::CDSSC_PIN_LAST) begin
            next_scan_state = SCAN_APPLY;
          end else begin
            next_pin = strap_scan_pin + 3'h1;
          end
        end else begin
          next_slot_cnt = slot_cnt + 4'h1;
        end
      end
      SCAN_APPLY: begin
        for (int i = 0; i < cdssc_pkg::CDSSC_NUM_OUT; i++) begin
          next_strap_set[i] = strap_cfg(shadow[i],
                                        shadow[cdssc_pkg::CDSSC_TYPE_PIN0 + i / 2],
                                        i[0]); // [R15] [R13]
        end
        next_strap_valid = 1'b1; // [R10]
        next_scan_state  = SCAN_IDLE;
      end
      default: begin
        next_scan_state = SCAN_IDLE;
      end
    endcase
    // Busy is registered from the next state, so it tracks the state flop exactly.
    next_busy = (next_scan_state != SCAN_IDLE);
  end

  // A scan starts straight out of reset, standing in for the power-on scan.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      scan_state     <= SCAN_RUN; // [R10]
      slot_cnt       <= '0;
      strap_scan_pin <= '0;
      strap_valid    <= 1'b0;
      strap_scan_busy <= 1'b1;
      sync_q         <= 1'b1;
      for (int p = 0; p < cdssc_pkg::CDSSC_NUM_PIN; p++) begin
        shadow[p] <= '0;
      end
      for (int i = 0; i < cdssc_pkg::CDSSC_NUM_OUT; i++) begin
        strap_set[i] <= '0;
      end
    end else begin
      scan_state     <= next_scan_state;
      slot_cnt       <= next_slot_cnt;
      strap_scan_pin <= next_pin;
      strap_valid    <= next_strap_valid;
      strap_scan_busy <= next_busy;
      sync_q         <= sync_n;
      for (int p = 0; p < cdssc_pkg::CDSSC_NUM_PIN; p++) begin
        shadow[p] <= next_shadow[p];
      end
      for (int i = 0; i < cdssc_pkg::CDSSC_NUM_OUT; i++) begin
        strap_set[i] <= next_strap_set[i];
      end
    end
  end

  // ****************************************************************
  // Outputs
  // ****************************************************************

  // Effective setting per output; strap outputs stay stopped until the first scan lands.
  genvar g;
  generate
    for (g = 0; g < cdssc_pkg::CDSSC_NUM_OUT; g++) begin : g_out
      always_comb begin
        eff_cfg[g] = strap_mode_select ? strap_set[g] : reg_cfg[g]; // [R08]
        if (strap_mode_select && !strap_valid) begin
          eff_cfg[g].enable = 1'b0;
        end
        hold[g]        = !sync_n && !eff_cfg[g].sync_mask; // [R05] [R06]
        active[g]      = eff_cfg[g].enable && !eff_cfg[g].power_down && !hold[g];
        hold_low[g]    = eff_cfg[g].level == cdssc_pkg::CDSSC_LVL_TOGGLE; // [R07]
        next_enable[g] = eff_cfg[g].enable && !eff_cfg[g].power_down;
        next_type[g]   = eff_cfg[g].level;
      end

      cdssc_divider u_div (
        .clk      (clk),
        .rst      (rst),
        .run      (next_enable[g]), // [R01]
        .hold     (hold[g]),
        .hold_low (hold_low[g]),
        .ratio_m1 (eff_cfg[g].ratio_m1),
        .clk_out  (clock_output[g])
      );
    end
  endgenerate

  // Driver enables and types are registered so every top output comes from a flop.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      output_enable <= '0; // [R02]
      output_type   <= '0;
    end else begin
      output_enable <= next_enable;
      output_type   <= next_type;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  pd_disable_a: assert property (!strap_mode_select && reg_cfg[0].power_down
                                 |=> !output_enable[0]) // [R01]
    else $error("Powered-down output still enabled.");
  strap_wr_ignored_a: assert property (strap_mode_select && reg_wr_en
                                       |=> $stable(reg_cfg[0])) // [R08]
    else $error("Register changed by a write in strap mode.");
  scan_start_a: assert property (scan_state == SCAN_IDLE && sync_rise
                                 |=> scan_state == SCAN_RUN && strap_scan_pin == 3'h0) // [R10]
    else $error("Sync release did not start a strap scan.");
  mask_runs_a: assert property (!sync_n && reg_cfg[3].sync_mask && !strap_mode_select
                                |-> !hold[3]) // [R06]
    else $error("Masked output was held during sync.");
  strap_apply_a: assert property (scan_state == SCAN_APPLY
                                  |=> strap_valid && strap_set[0].ratio_m1 ==
                                      cdssc_pkg::CDSSC_STRAP_RATIO_M1[$past(shadow[0])]) // [R12]
    else $error("Strap ratio not latched at scan end.");
  unmapped_zero_a: assert property (reg_rd_en && !rd_dec.hit |=> reg_rd_valid && reg_rdata == '0)
    else $error("Unmapped read returned nonzero data.");

endmodule

// file: tb/cdssc_strap_model.sv
// Model of the six strap pins as seen through the scanning converter.
`timescale 1ns/1ps
module cdssc_strap_model (
  input  wire logic            clk,
  input  wire logic            busy,
  input  wire logic [2:0]      pin,
  input  wire logic [5:0][2:0] lv,
  output logic      [2:0]      level
);
  logic [2:0] last;
  // ****************************************************************
  // Level answer
  // ****************************************************************
  // Outside a scan the level flips every cycle, so a stale sample shows up.
  always_comb begin
    if (busy && pin < 3'h6) begin
      level = lv[pin];
    end else begin
      level = ~last;
    end
  end
  // Last level, kept only to make the idle pattern.
  always_ff @(posedge clk) begin
    last <= level;
  end
endmodule

// file: tb/tb.sv
// Self-checking bench for the divider control block.
`timescale 1ns/1ps
module tb;
  logic            clk, rst, sync_n, sel, wr, rd, rvalid, busy, pdn;
  logic [2:0]      lvl, pin;
  logic [12:0]     addr;
  logic [7:0]      wd, rdata;
  logic [3:0]      co, oe, eoe;
  logic [3:0][1:0] ot;
  logic [5:0][2:0] lv;
  logic [31:0]     seed;
  int              failures, check_count, n[4];

  cdssc_ctrl DUT (.clk(clk), .rst(rst), .sync_n(sync_n), .strap_mode_select(sel),
    .strap_level(lvl), .reg_wr_en(wr), .reg_rd_en(rd), .reg_addr(addr),
    .reg_wdata(wd), .reg_rdata(rdata), .reg_rd_valid(rvalid), .clock_output(co),
    .output_enable(oe), .output_type(ot), .strap_scan_pin(pin),
    .strap_scan_busy(busy), .device_power_down(pdn));
  cdssc_strap_model u_strap (.clk(clk), .busy(busy), .pin(pin), .lv(lv), .level(lvl));

  // ****************************************************************
  // Helpers
  // ****************************************************************
  function automatic logic [31:0] xs(input logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    return s ^ (s << 5);
  endfunction
  // Type per level: 0 LVDS, 1 HSTL, 2 high impedance.
  function automatic logic [1:0] ptype(input logic [2:0] l, input int odd);
    logic [15:0] ev, od;
    ev = 16'h9861;
    od = 16'hA015;
    return (odd != 0) ? od[2*l +: 2] : ev[2*l +: 2];
  endfunction
  function automatic int rat(input logic [2:0] l);
    return (l < 3'h6) ? int'(l) + 1 : ((l == 3'h6) ? 8 : 16);
  endfunction
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    check_count++;
    if (seen !== exp) begin
      failures++;
      $display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  // Inputs always move one nanosecond after the rising edge.
  task automatic cyc(input int k);
    repeat (k) @(posedge clk);
    #1;
  endtask
  task automatic wrr(input logic [12:0] a, input logic [7:0] d);
    addr = a;
    wd = d;
    wr = 1'b1;
    cyc(1);
    wr = 1'b0;
    // One idle edge, so a following call never lifts the strobe in this time step.
    cyc(1);
  endtask
  task automatic rdr(input logic [12:0] a, input logic [7:0] e);
    addr = a;
    rd = 1'b1;
    cyc(1);
    rd = 1'b0;
    chk(8'(rvalid), 8'h01);
    chk(rdata, e);
    cyc(1);
  endtask
  // Cycles between two toggles of one output.
  task automatic per(input int k, input int e);
    logic v;
    int   c;
    for (int i = 0; i < 2; i++) begin
      v = co[k];
      c = 0;
      while (co[k] === v && c < 40) begin
        cyc(1);
        c++;
      end
    end
    chk(8'(c), 8'(e));
  endtask
  task automatic sync_run();
    int   c;
    logic m;
    sync_n = 1'b0;
    cyc(3);
    c = 0;
    for (int i = 0; i < 8; i++) begin
      m = co[3];
      chk(8'(co[2:0]), 8'h00);
      cyc(1);
      c += (co[3] !== m);
    end
    chk(8'(c > 5), 8'h01);
    sync_n = 1'b1;
    c = 0;
    while (co[2:0] !== 3'h7 && c < 10) begin
      cyc(1);
      c++;
    end
    chk(8'(c < 10), 8'h01);
    for (int t = 0; t < 24; t++) begin
      chk(8'(co[2:0]), 8'({(t/n[2])%2 == 0, (t/n[1])%2 == 0, (t/n[0])%2 == 0}));
      cyc(1);
    end
  endtask
  task automatic end_sim();
    $display("checks %0d failures %0d", check_count, failures);
    if (failures == 0 && check_count > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  // ****************************************************************
  // Clock, watchdog and main sequence
  // ****************************************************************
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  // The whole run needs well under ten thousand cycles.
  initial begin
    #200000;
    failures++;
    end_sim();
  end
  initial begin
    rst = 1'b1; sync_n = 1'b1; sel = 1'b0; wr = 1'b0; rd = 1'b0;
    addr = 13'h0000; wd = 8'h00; lv = '0; seed = 32'h00004D57;
    cyc(4);
    chk(8'({pdn, oe}), 8'h10);
    rst = 1'b0;
    cyc(2);
    chk(8'({pdn, oe}), 8'h0F);
    chk(8'(co == 4'h0 || co == 4'hF), 8'h01);
    for (int k = 0; k < 4; k++) per(k, 1);
    rdr(13'h0019, 8'h34);
    rdr(13'h0000, 8'h00);
    for (int k = 0; k < 4; k++) begin
      wrr(cdssc_pkg::CDSSC_CTRL_ADDR[k], 8'hB0);
      cyc(2);
      chk(8'(oe), 8'(4'hF & ~(4'h1 << k)));
      wrr(cdssc_pkg::CDSSC_CTRL_ADDR[k], 8'h30);
    end
    for (int k = 0; k < 3; k++) begin
      seed = xs(seed);
      n[k] = int'(seed % 6) + 1;
      wrr(cdssc_pkg::CDSSC_CTRL_ADDR[k] + 13'h0001, 8'(n[k] - 1));
      rdr(cdssc_pkg::CDSSC_CTRL_ADDR[k] + 13'h0001, 8'(n[k] - 1));
    end
    wrr(cdssc_pkg::CDSSC_CTRL_ADDR[3], 8'h70);
    cyc(2);
    sync_run();
    rst = 1'b1;
    #1;
    chk(8'({pdn, oe}), 8'h10);
    cyc(1);
    rst = 1'b0;
    sel = 1'b1;
    cyc(2);
    for (int r = 0; r < 8; r++) begin
      for (int k = 0; k < 4; k++) begin
        seed = xs(seed);
        lv[k] = (r == 0) ? 3'h7 : seed[2:0];
      end
      lv[4] = 3'(r);
      lv[5] = 3'(7 - r);
      wrr(13'h0019, 8'hB0);
      cyc(60);
      if (r > 0) chk(8'(oe), 8'(eoe));
      sync_n = 1'b0;
      cyc(2);
      sync_n = 1'b1;
      cyc(2);
      for (int c = 0; c < 100 && busy !== 1'b0; c++) cyc(1);
      chk(8'(busy), 8'h00);
      cyc(2);
      for (int k = 0; k < 4; k++) begin
        eoe[k] = (ptype(lv[4 + k/2], k % 2) != 2'h2);
        if (eoe[k]) begin
          chk(8'({oe[k], ot[k]}), 8'({1'b1, ptype(lv[4 + k/2], k % 2)}));
          per(k, rat(lv[k]));
        end else begin
          chk(8'(oe[k]), 8'h00);
        end
      end
    end
    end_sim();
  end
endmodule
